// >>> hdl/clkgen_pkg.sv
// Purpose: Shared constants for the CPU clock generator
// Assumes: clk_sys is the system clock (fx), 40 MHz
// Notes: Select codes above the slowest are reserved

package clkgen_pkg;

	// ************************************************
	// Divider control register
	// ************************************************
	localparam logic [7:0] DIV_CTRL_RESET = 8'h04;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_FASTEST = 3'h0;
	localparam logic [2:0] SEL_SLOWEST = 3'h4;

	// ************************************************
	// Timing
	// ************************************************
	// Oscillation settle time, in system clock periods (2^17)
	localparam int OSC_STAB_PERIODS = 131072;
	// Switch delay in old minimum instruction times, from setting 000
	localparam logic [4:0] SWITCH_INSTR_BASE = 5'h10;
	// Prescaler width: fx/2 .. fx/16
	localparam int PRESC_W = 4;

	typedef enum logic [1:0] {
		ST_STAB,
		ST_RUN,
		ST_HALT,
		ST_STOP
	} gen_state_t;

endpackage

// >>> hdl/cpu_clk_if.sv
// Purpose: Carrier between clock control and prescaler
// Assumes: Single clock domain, clk_sys
// Notes: Enables are one-cycle pulses

`timescale 1ns/1ps

interface cpu_clk_if;
	logic run;
	logic restart;
	logic [clkgen_pkg::SEL_W-1:0] sel;
	logic cpu_en;
	logic [clkgen_pkg::PRESC_W-1:0] tap_en;

	modport ctrl
	(
		output run,
		output restart,
		output sel,
		input cpu_en,
		input tap_en
	);

	modport div
	(
		input run,
		input restart,
		input sel,
		output cpu_en,
		output tap_en
	);
endinterface

// >>> hdl/clk_prescaler.sv
// Purpose: Divides fx into CPU and peripheral clock enables
// Assumes: sel already mapped to a legal code 0..4
// Notes: Restart realigns the count at a switch boundary

`timescale 1ns/1ps

module clk_prescaler
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	cpu_clk_if.div ci
);

	// ************************************************
	// Counter
	// ************************************************
	logic [clkgen_pkg::PRESC_W-1:0] cnt_reg;
	logic [clkgen_pkg::PRESC_W-1:0] cnt_next;
	logic [clkgen_pkg::PRESC_W:0] mask_wide;
	logic [clkgen_pkg::PRESC_W-1:0] mask;

	always_comb
	begin
		cnt_next = cnt_reg;
		if (ci.restart)
			cnt_next = '0;
		else if (ci.run)
			cnt_next = cnt_reg + 4'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	// ************************************************
	// Enables
	// ************************************************
	// Stopped fx stops every peripheral tap too
	genvar k;
	generate
		for (k = 1; k <= clkgen_pkg::PRESC_W; k++)
		begin : g_tap
			assign ci.tap_en[k-1] = ci.run && (&cnt_reg[k-1:0]);
		end
	endgenerate

	// Pulse on the last count of each period, never a short one
	assign mask_wide = (5'h01 << ci.sel) - 5'h01;
	assign mask = mask_wide[clkgen_pkg::PRESC_W-1:0];
	assign ci.cpu_en = ci.run && ((cnt_reg & mask) == mask);

endmodule

// >>> hdl/cpu_clock_divider_select.sv
// Purpose: CPU clock divider select, oscillator start and standby control
// Assumes: Register and standby requests come from logic on clk_sys
// Notes: CPU clock is an enable pulse; one clock domain only
//
// Behaviour
// - Reset loads the divider control register with 04H, slowest setting.
// - Low three bits select fx, fx/2, fx/4, fx/8 or fx/16.
// - Register writable as one bit or as a whole byte.
// - Minimum instruction time is two CPU clock periods.
// - Old clock kept 16/8/4/2/1 old instructions after a select change.
// - Oscillator stays stopped while reset is held.
// - After reset, wait 2^17 fx periods before the CPU runs.
// - CPU then starts on fx/16.
// - Peripheral clocks divide fx, halting when fx stops.
// - Two standby modes: halt execution only, or stop the oscillator.
// - Oscillator stop halts fx and pulls the return pin high.
// - Oscillator stop standby stops oscillation entirely.

`timescale 1ns/1ps

module cpu_clock_divider_select
#(
	parameter int STAB_PERIODS = clkgen_pkg::OSC_STAB_PERIODS
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr_byte,
	input wire logic reg_wr_bit,
	input wire logic [2:0] reg_bit_idx,
	input wire logic reg_bit_val,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic halt_req,
	input wire logic stop_req,
	input wire logic wake_req,
	output logic osc_run,
	output logic oscillator_return_pin_pullup,
	output logic cpu_clk_en,
	output logic instr_en,
	output logic [clkgen_pkg::PRESC_W-1:0] periph_clk_en,
	output logic cpu_running,
	output logic switch_busy
);

	// ************************************************
	// Helpers
	// ************************************************
	// Reserved codes fall back to the slowest clock
	function automatic logic [2:0] legal_sel(input logic [2:0] code);
		legal_sel = (code > clkgen_pkg::SEL_SLOWEST) ?
			clkgen_pkg::SEL_SLOWEST : code;
	endfunction

	cpu_clk_if ci();

	clk_prescaler u_presc
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ci(ci)
	);

	// ************************************************
	// Control register
	// ************************************************
	logic [7:0] div_ctrl_reg;
	logic [7:0] div_ctrl_next;
	logic [2:0] target_sel;

	always_comb
	begin
		div_ctrl_next = div_ctrl_reg;
		if (reg_wr_byte)
			div_ctrl_next = reg_wdata;
		else if (reg_wr_bit)
			div_ctrl_next[reg_bit_idx] = reg_bit_val;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			div_ctrl_reg <= clkgen_pkg::DIV_CTRL_RESET;
		else
			div_ctrl_reg <= div_ctrl_next;
	end

	assign reg_rdata = div_ctrl_reg;
	// Upper bits are stored but never steer the divider
	assign target_sel = legal_sel(
		div_ctrl_reg[clkgen_pkg::SEL_LSB +: clkgen_pkg::SEL_W]);

	// ************************************************
	// Oscillator and standby state
	// ************************************************
	clkgen_pkg::gen_state_t state_reg;
	clkgen_pkg::gen_state_t state_next;
	logic [17:0] stab_cnt_reg;
	logic [17:0] stab_cnt_next;
	logic [17:0] stab_last;

	assign stab_last = 18'(STAB_PERIODS - 1);

	always_comb
	begin
		state_next = state_reg;
		stab_cnt_next = stab_cnt_reg;
		unique case (state_reg)
			clkgen_pkg::ST_STAB:
			begin
				// Settle wait after reset or oscillator restart
				if (stab_cnt_reg == stab_last)
					state_next = clkgen_pkg::ST_RUN;
				else
					stab_cnt_next = stab_cnt_reg + 18'h1;
			end
			clkgen_pkg::ST_RUN:
			begin
				if (stop_req)
					state_next = clkgen_pkg::ST_STOP;
				else if (halt_req)
					state_next = clkgen_pkg::ST_HALT;
			end
			clkgen_pkg::ST_HALT:
			begin
				if (wake_req)
					state_next = clkgen_pkg::ST_RUN;
			end
			clkgen_pkg::ST_STOP:
			begin
				// Restarting fx needs the full settle wait again
				if (wake_req)
				begin
					state_next = clkgen_pkg::ST_STAB;
					stab_cnt_next = '0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_reg <= clkgen_pkg::ST_STAB;
			stab_cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			stab_cnt_reg <= stab_cnt_next;
		end
	end

	// ************************************************
	// Clock switch
	// ************************************************
	logic [2:0] sel_active_reg;
	logic [2:0] sel_active_next;
	logic pending_reg;
	logic pending_next;
	logic [4:0] instr_left_reg;
	logic [4:0] instr_left_next;
	logic phase_reg;
	logic phase_next;
	logic restart;

	always_comb
	begin
		sel_active_next = sel_active_reg;
		pending_next = pending_reg;
		instr_left_next = instr_left_reg;
		phase_next = phase_reg;
		restart = 1'b0;
		// Count only CPU clocks that run; standby starts a fresh instruction
		if (cpu_clk_en)
			phase_next = ~phase_reg;
		else if (!cpu_running)
			phase_next = 1'b0;
		if (!pending_reg && target_sel != sel_active_reg)
		begin
			pending_next = 1'b1;
			instr_left_next = clkgen_pkg::SWITCH_INSTR_BASE >>
				sel_active_reg;
		end
		else if (pending_reg && instr_en)
		begin
			if (instr_left_reg == 5'h01)
			begin
				// Switch at an instruction end, counter realigned
				sel_active_next = target_sel;
				pending_next = 1'b0;
				phase_next = 1'b0;
				restart = 1'b1;
			end
			else
				instr_left_next = instr_left_reg - 5'h01;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sel_active_reg <= clkgen_pkg::SEL_SLOWEST;
			pending_reg <= 1'b0;
			instr_left_reg <= '0;
			phase_reg <= 1'b0;
		end
		else
		begin
			sel_active_reg <= sel_active_next;
			pending_reg <= pending_next;
			instr_left_reg <= instr_left_next;
			phase_reg <= phase_next;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign osc_run = !sys_rst && state_reg != clkgen_pkg::ST_STOP;
	assign oscillator_return_pin_pullup =
		state_reg == clkgen_pkg::ST_STOP;
	assign cpu_running = state_reg == clkgen_pkg::ST_RUN;

	assign ci.run = osc_run;
	assign ci.restart = restart;
	assign ci.sel = sel_active_reg;

	// Halt gates only the CPU; peripherals keep their clocks
	assign cpu_clk_en = ci.cpu_en && cpu_running;
	assign instr_en = cpu_clk_en && phase_reg;
	assign periph_clk_en = ci.tap_en;
	assign switch_busy = pending_reg;

endmodule

// >>> dv/cpu_clock_divider_select_chk.sv
// Purpose: Port assertions for the CPU clock divider select
// Assumes: One clock, clk_sys; synchronous reset
// Notes: Reset checks stay live while reset is held
`timescale 1ns/1ps
module cpu_clock_divider_select_chk
#(
	parameter int STAB_PERIODS = clkgen_pkg::OSC_STAB_PERIODS
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr_byte,
	input wire logic reg_wr_bit,
	input wire logic [2:0] reg_bit_idx,
	input wire logic reg_bit_val,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic stop_req,
	input wire logic osc_run,
	input wire logic oscillator_return_pin_pullup,
	input wire logic cpu_clk_en,
	input wire logic instr_en,
	input wire logic [clkgen_pkg::PRESC_W-1:0] periph_clk_en,
	input wire logic cpu_running
);
	// ****************
	// Helpers
	// ****************
	int since_rel = 0;
	logic odd_seen = 1'b0;
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			since_rel <= 0;
		else if (since_rel <= STAB_PERIODS)
			since_rel <= since_rel + 1;
		if (sys_rst || !cpu_running || instr_en)
			odd_seen <= 1'b0;
		else if (cpu_clk_en)
			odd_seen <= 1'b1;
	end
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_sys); endclocking
	sequence s_stopped;
		!osc_run && oscillator_return_pin_pullup;
	endsequence
	property p_rst; sys_rst |=> reg_rdata == 8'h04; endproperty
	a_rst: assert property (p_rst)
		else $error("reset value wrong");
	property p_off; sys_rst |-> !osc_run && !cpu_clk_en; endproperty
	a_off: assert property (p_off)
		else $error("oscillator runs in reset");
	property p_settle;
		disable iff (sys_rst) $fell(sys_rst) |-> !cpu_clk_en [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("cpu clock before settle");
	property p_instr;
		instr_en || cpu_clk_en |-> cpu_clk_en && instr_en == odd_seen;
	endproperty
	a_instr: assert property (p_instr)
		else $error("instruction end not every second cpu clock");
	property p_wait;
		disable iff (sys_rst) since_rel < STAB_PERIODS |-> !cpu_running;
	endproperty
	a_wait: assert property (p_wait)
		else $error("cpu ran before the settle wait ended");
	property p_go;
		disable iff (sys_rst) since_rel == STAB_PERIODS |-> cpu_running;
	endproperty
	a_go: assert property (p_go)
		else $error("cpu not running after the settle wait");
	property p_byte;
		disable iff (sys_rst) reg_wr_byte |=> reg_rdata == $past(reg_wdata);
	endproperty
	a_byte: assert property (p_byte)
		else $error("byte write lost");
	property p_bit;
		disable iff (sys_rst) reg_wr_bit && !reg_wr_byte
			|=> reg_rdata[$past(reg_bit_idx)] == $past(reg_bit_val);
	endproperty
	a_bit: assert property (p_bit)
		else $error("bit write lost");
	property p_stop;
		disable iff (sys_rst) stop_req && cpu_running |=> s_stopped;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop did not halt oscillator");
	property p_quiet; !osc_run |-> periph_clk_en == '0 && !cpu_clk_en; endproperty
	a_quiet: assert property (p_quiet)
		else $error("clock enable while oscillator off");
endmodule

bind cpu_clock_divider_select cpu_clock_divider_select_chk
	#(.STAB_PERIODS(STAB_PERIODS)) u_chk
(
	.clk_sys, .sys_rst, .reg_wr_byte, .reg_wr_bit, .reg_bit_idx,
	.reg_bit_val, .reg_wdata, .reg_rdata, .stop_req, .osc_run,
	.oscillator_return_pin_pullup, .cpu_clk_en, .instr_en,
	.periph_clk_en, .cpu_running
);

// >>> dv/cpu_sink_model.sv
// Purpose: CPU side sink timing the CPU clock enables
// Assumes: Enables are one-cycle pulses on clk_sys
// Notes: Only measures; never drives the block
`timescale 1ns/1ps
module cpu_sink_model
(
	input wire logic clk_sys,
	input wire logic cpu_clk_en,
	input wire logic instr_en,
	input wire logic switch_busy,
	output logic [31:0] gap,
	output logic [31:0] ninstr
);
	logic [31:0] cnt = 32'h0;
	logic busy_d = 1'b0;
	initial gap = 32'h0;
	initial ninstr = 32'h0;
	always @(posedge clk_sys)
	begin
		busy_d <= switch_busy;
		cnt <= cpu_clk_en ? 32'h0 : cnt + 32'h1;
		if (cpu_clk_en)
			gap <= cnt + 32'h1;
		// Restart on each new pending switch
		if (switch_busy && !busy_d)
			ninstr <= {31'h0, instr_en};
		else if (switch_busy && instr_en)
			ninstr <= ninstr + 32'h1;
	end
endmodule

// >>> dv/cpu_clock_divider_select_tb_top.sv
// Purpose: Self-checking bench for the CPU clock divider select
// Assumes: Settle wait cut to 16 cycles
// Notes: Random codes, reserved code as a corner
`timescale 1ns/1ps
module cpu_clock_divider_select_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr_byte = 1'b0;
	logic reg_wr_bit = 1'b0;
	logic [2:0] reg_bit_idx = 3'h0;
	logic reg_bit_val = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic halt_req = 1'b0;
	logic stop_req = 1'b0;
	logic wake_req = 1'b0;
	logic [7:0] reg_rdata;
	logic osc_run, oscillator_return_pin_pullup, cpu_clk_en, instr_en;
	logic cpu_running, switch_busy;
	logic [clkgen_pkg::PRESC_W-1:0] periph_clk_en;
	logic [31:0] gap, ninstr;
	logic [2:0] old, sel;
	int bad_count = 0;
	int tests_run = 0;
	int n;
	int m;
	cpu_clock_divider_select #(.STAB_PERIODS(16)) u_dut
	(
		.clk_sys, .sys_rst, .reg_wr_byte, .reg_wr_bit, .reg_bit_idx,
		.reg_bit_val, .reg_wdata, .reg_rdata, .halt_req, .stop_req,
		.wake_req, .osc_run, .oscillator_return_pin_pullup, .cpu_clk_en,
		.instr_en, .periph_clk_en, .cpu_running, .switch_busy
	);
	cpu_sink_model u_cpu
	(
		.clk_sys, .cpu_clk_en, .instr_en, .switch_busy, .gap, .ninstr
	);
	// ****************
	// Helpers
	// ****************
	initial forever #12.5 clk_sys = ~clk_sys;
	function automatic logic [2:0] eff(input logic [2:0] s);
		return (s > 3'h4) ? 3'h4 : s;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// Sample at the falling edge, away from the updates
	task automatic waitfor(input bit busy);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while ((busy ? switch_busy : !cpu_running) !== 1'b0 && n < 2000);
		// A wait that runs out is a mismatch
		check({31'h0, n < 2000}, 32'h1);
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [2:0] s);
		reg_wr_byte <= 1'b1;
		reg_wdata <= {5'h00, s};
		tick(2);
		reg_wr_byte <= 1'b0;
		tick(1);
		check(reg_rdata, {5'h00, s});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		tick(20000);
		bad_count++;
		results();
	end
	// ****************
	// Scenarios
	// ****************
	initial
	begin
		void'($urandom(32'h06376eb1));
		tick(3);
		check(reg_rdata, 32'h04);
		check(osc_run, 32'h0);
		sys_rst <= 1'b0;
		waitfor(0);
		check(n >= 16, 32'h1);
		tick(50);
		check(gap, 32'h10);
		old = 3'h4;
		for (int i = 0; i < 8; i++)
		begin
			sel = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom_range(4));
			if (eff(sel) == old)
				sel = (old == 3'h4) ? 3'h0 : old + 3'h1;
			wr(sel);
			waitfor(1);
			tick(50);
			check(gap, 32'h1 << eff(sel));
			check(ninstr, 32'h10 >> old);
			old = eff(sel);
		end
		reg_bit_idx <= 3'h1;
		reg_bit_val <= ~old[1];
		reg_wr_bit <= 1'b1;
		tick(1);
		reg_wr_bit <= 1'b0;
		tick(1);
		check(reg_rdata, {5'h00, old ^ 3'h2});
		waitfor(1);
		halt_req <= 1'b1;
		tick(1);
		halt_req <= 1'b0;
		n = 0;
		m = 0;
		// Halt stops the CPU only; the fx/2 tap keeps pulsing
		repeat (40)
		begin
			@(negedge clk_sys);
			n += int'(cpu_clk_en);
			m += int'(periph_clk_en[0]);
		end
		check(n, 32'h0);
		check(m, 32'h14);
		@(posedge clk_sys);
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(2);
		check(cpu_running, 32'h1);
		stop_req <= 1'b1;
		tick(1);
		stop_req <= 1'b0;
		@(negedge clk_sys);
		check(oscillator_return_pin_pullup, 32'h1);
		check(osc_run, 32'h0);
		check(periph_clk_en, 32'h0);
		@(posedge clk_sys);
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		waitfor(0);
		check(n >= 16, 32'h1);
		wr(3'h0);
		results();
	end
endmodule
